// file: logic/urs_receive_status.sv
// Summary of operation
// - Address detect acts only when enable is set and 9-bit framing selected.
// - In address detect, a character with bit 8 set is an address.
// - Receiver idle flag reads one when idle, zero while receiving.
// - Parity error flag reflects the character at the head of the buffer.
// - Framing error flag reflects the character at the head of the buffer.
// - Overrun flag set by hardware on buffer overflow, else zero.
// - Clearing a set overrun flag empties buffer and shift register.
// - Data-available flag reads one while buffer holds an unread character.
// - Parity, framing, idle and data-available flags ignore software writes.
// - Select field value binary 11 chooses 9-bit data without parity.
// - Receive buffer holds up to four characters.
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`default_nettype none
module urs_receive_status
   import urs_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic rxPin,
   output logic irq
);

   typedef struct packed {
      // Pin synchroniser and receiver
      logic rxMeta;
      logic rxSync;
      urs_rx_e rxState;
      logic [15:0] baudCnt;
      logic [3:0] bitCnt;
      logic [8:0] shift;
      logic parityErr;

      // Four-entry buffer; each entry carries its own error bits
      logic [FIFO_DEPTH-1:0][10:0] fifo;
      logic [1:0] wrPtr;
      logic [1:0] rdPtr;
      logic [2:0] count;

      // Software-visible settings
      logic addrDetectEn;
      logic [1:0] parity_data_select;
      logic [15:0] brgDiv;
      logic overrun;
      logic [INT_W-1:0] intStat;
      logic [INT_W-1:0] intMask;

      // Bus pipeline: a write is held over into its data phase
      logic wrPend;
      logic [7:0] wrAddr;
      logic [31:0] rdata;
      logic readyOut;
      logic irqOut;
   } urs_state_s;

   urs_state_s s_q;
   urs_state_s s_d;

   function automatic logic nineBit(input logic [1:0] sel);
      nineBit = (sel == PARITY_DATA_SELECT_9N);
   endfunction

   // Buffer occupancy test shared by the status view and the read pop
   function automatic logic hasData(input logic [2:0] cnt);
      hasData = (cnt != 3'h0);
   endfunction

   // One full bit time, counted down to zero
   function automatic logic [15:0] bitReload(input logic [15:0] div);
      bitReload = div - 16'h0001;
   endfunction

   urs_char_s head;
   urs_char_s newChar;
   logic addrPhase;
   logic doRead;
   logic pop;
   logic push;
   logic flush;
   logic baudTick;
   logic charDone;
   logic [INT_W-1:0] events;
   logic [INT_W-1:0] w1c;
   logic [15:0] staRead;

   always_comb begin
      s_d = s_q;
      head = urs_char_s'(s_q.fifo[s_q.rdPtr]);
      newChar = '0;
      pop = 1'b0;
      push = 1'b0;
      flush = 1'b0;
      charDone = 1'b0;
      events = '0;
      w1c = '0;

      s_d.rxMeta = rxPin;
      s_d.rxSync = s_q.rxMeta;
      s_d.readyOut = 1'b1;

      // Status view; flags from the head entry are only meaningful while data is held
      staRead = '0;
      staRead[STA_ADDRESS_DETECT_ENABLE] = s_q.addrDetectEn;
      staRead[STA_RECEIVER_IDLE_FLAG] = (s_q.rxState == RX_IDLE);
      staRead[STA_PARITY_ERROR_FLAG] = hasData(s_q.count) && head.parityErr;
      staRead[STA_FRAMING_ERROR_FLAG] = hasData(s_q.count) && head.framingErr;
      staRead[STA_OVERRUN_ERROR_FLAG] = s_q.overrun;
      staRead[STA_RXDA] = hasData(s_q.count);

      // Reads are decoded in the address phase so hrdata can leave a flip-flop
      addrPhase = hsel && htrans[1] && hready;
      doRead = addrPhase && !hwrite;
      s_d.wrPend = addrPhase && hwrite;
      if (addrPhase) begin
         s_d.wrAddr = haddr[7:0];
      end
      if (doRead) begin
         case (haddr[7:0])
            STA_OFF: begin
               s_d.rdata = {16'h0000, staRead};
            end
            MODE_OFF: begin
               s_d.rdata = {29'h00000000, s_q.parity_data_select, 1'b0};
            end
            BRG_OFF: begin
               s_d.rdata = {16'h0000, s_q.brgDiv};
            end
            // Popping here means the word leaves the buffer before the master has taken it
            RXDATA_OFF: begin
               s_d.rdata = {23'h000000, head.data};
               pop = hasData(s_q.count);
            end
            INTSTAT_OFF: begin
               s_d.rdata = {28'h0000000, s_q.intStat};
            end
            INTMASK_OFF: begin
               s_d.rdata = {28'h0000000, s_q.intMask};
            end
            default: begin
               s_d.rdata = 32'h00000000;
            end
         endcase
      end

      // Writes land in the data phase; read-only status bits are simply not stored
      if (s_q.wrPend) begin
         case (s_q.wrAddr)
            STA_OFF: begin
               s_d.addrDetectEn = hwdata[STA_ADDRESS_DETECT_ENABLE];
               if (s_q.overrun && !hwdata[STA_OVERRUN_ERROR_FLAG]) begin
                  flush = 1'b1;
               end
            end
            // Changing the format mid-character applies to the remaining bits
            MODE_OFF: begin
               s_d.parity_data_select = hwdata[MODE_PARITY_DATA_SELECT_LO +: 2];
            end
            BRG_OFF: begin
               s_d.brgDiv = hwdata[15:0];
            end
            INTSTAT_OFF: begin
               w1c = hwdata[INT_W-1:0];
            end
            INTMASK_OFF: begin
               s_d.intMask = hwdata[INT_W-1:0];
            end
            default: ;
         endcase
      end

      // Bit timing: brgDiv clocks per bit, start bit checked at its middle
      baudTick = (s_q.baudCnt == 16'h0000);
      if (!baudTick) begin
         s_d.baudCnt = s_q.baudCnt - 16'h0001;
      end
      case (s_q.rxState)
         RX_IDLE: begin
            if (!s_q.rxSync) begin
               s_d.rxState = RX_START;
               s_d.baudCnt = {1'b0, s_q.brgDiv[15:1]};
            end
         end
         RX_START: begin
            if (baudTick) begin
               // A start bit gone high by its middle was a glitch
               s_d.rxState = s_q.rxSync ? RX_IDLE : RX_DATA;
               s_d.baudCnt = bitReload(s_q.brgDiv);
               s_d.bitCnt = 4'h0;
               s_d.shift = '0;
            end
         end
         RX_DATA: begin
            if (baudTick) begin
               s_d.shift[s_q.bitCnt] = s_q.rxSync;
               s_d.bitCnt = s_q.bitCnt + 4'h1;
               s_d.baudCnt = bitReload(s_q.brgDiv);
               s_d.parityErr = 1'b0;
               if (s_q.bitCnt == (nineBit(s_q.parity_data_select) ? 4'h8 : 4'h7)) begin
                  if (s_q.parity_data_select == PARITY_DATA_SELECT_8N || nineBit(s_q.parity_data_select)) begin
                     s_d.rxState = RX_STOP;
                  end else begin
                     s_d.rxState = RX_PARITY;
                  end
               end
            end
         end
         RX_PARITY: begin
            if (baudTick) begin
               s_d.parityErr = (^s_q.shift[7:0]) ^ s_q.rxSync ^ (s_q.parity_data_select == PARITY_DATA_SELECT_8O);
               s_d.baudCnt = bitReload(s_q.brgDiv);
               s_d.rxState = RX_STOP;
            end
         end
         // Only one stop bit is checked, at its middle, so a back-to-back start is not missed
         RX_STOP: begin
            if (baudTick) begin
               charDone = 1'b1;
               s_d.rxState = RX_IDLE;
            end
         end
         default: begin
            s_d.rxState = RX_IDLE;
         end
      endcase

      newChar.data = s_q.shift;
      newChar.parityErr = s_q.parityErr;
      newChar.framingErr = !s_q.rxSync;
      // Address detect needs 9-bit framing; data characters are dropped silently
      if (charDone && !s_q.overrun) begin
         if (s_q.addrDetectEn && nineBit(s_q.parity_data_select) && !s_q.shift[8]) begin
            push = 1'b0;
         end else if (s_q.count == FIFO_FULL && !pop) begin
            s_d.overrun = 1'b1;
            events[INT_OVERRUN] = 1'b1;
         end else begin
            push = 1'b1;
            events[INT_RXCHAR] = 1'b1;
            events[INT_PARITY] = newChar.parityErr;
            events[INT_FRAMING] = newChar.framingErr;
         end
      end

      if (push) begin
         s_d.fifo[s_q.wrPtr] = newChar;
         s_d.wrPtr = s_q.wrPtr + 2'h1;
      end
      if (pop) begin
         s_d.rdPtr = s_q.rdPtr + 2'h1;
      end
      s_d.count = s_q.count + {2'h0, push} - {2'h0, pop};

      // Overrun clear: buffer and shift register both restart empty
      if (flush) begin
         s_d.overrun = 1'b0;
         s_d.count = 3'h0;
         s_d.wrPtr = 2'h0;
         s_d.rdPtr = 2'h0;
         s_d.rxState = RX_IDLE;
         s_d.shift = '0;
         s_d.bitCnt = 4'h0;
      end

      // A new event beats a simultaneous write-one-to-clear
      // The level output follows the next state so it is one flop away from the event
      s_d.intStat = (s_q.intStat & ~w1c) | events;
      s_d.irqOut = |(s_d.intStat & s_d.intMask);
   end

   // Line and synchroniser start high so reset does not look like a start bit
   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= '0;
         s_q.rxMeta <= 1'b1;
         s_q.rxSync <= 1'b1;
         s_q.rxState <= RX_IDLE;
         s_q.brgDiv <= BRG_RESET;
         s_q.parity_data_select <= PARITY_DATA_SELECT_RESET;
         s_q.intMask <= INTMASK_RESET;
         s_q.readyOut <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign hreadyout = s_q.readyOut;
   assign hrdata = s_q.rdata;
   assign hresp = 1'b0;
   assign irq = s_q.irqOut;

endmodule
`default_nettype wire

// file: logic/urs_pkg.sv
`default_nettype none
package urs_pkg;
   // Register byte offsets
   localparam logic [7:0] STA_OFF = 8'h00;
   localparam logic [7:0] MODE_OFF = 8'h04;
   localparam logic [7:0] BRG_OFF = 8'h08;
   localparam logic [7:0] RXDATA_OFF = 8'h0C;
   localparam logic [7:0] INTSTAT_OFF = 8'h10;
   localparam logic [7:0] INTMASK_OFF = 8'h14;
   // Status/control field positions
   localparam int STA_ADDRESS_DETECT_ENABLE = 5;
   localparam int STA_RECEIVER_IDLE_FLAG = 4;
   localparam int STA_PARITY_ERROR_FLAG = 3;
   localparam int STA_FRAMING_ERROR_FLAG = 2;
   localparam int STA_OVERRUN_ERROR_FLAG = 1;
   localparam int STA_RXDA = 0;
   // Mode register: data/parity select field
   localparam int MODE_PARITY_DATA_SELECT_LO = 1;
   localparam logic [1:0] PARITY_DATA_SELECT_8N = 2'h0;
   localparam logic [1:0] PARITY_DATA_SELECT_8E = 2'h1;
   localparam logic [1:0] PARITY_DATA_SELECT_8O = 2'h2;
   localparam logic [1:0] PARITY_DATA_SELECT_9N = 2'h3;
   // Interrupt status/mask bits
   localparam int INT_RXCHAR = 0;
   localparam int INT_OVERRUN = 1;
   localparam int INT_PARITY = 2;
   localparam int INT_FRAMING = 3;
   localparam int INT_W = 4;
   // Receive buffer
   localparam int FIFO_DEPTH = 4;
   localparam logic [2:0] FIFO_FULL = 3'h4;
   // Reset values
   localparam logic [15:0] BRG_RESET = 16'h0010;
   localparam logic [1:0] PARITY_DATA_SELECT_RESET = 2'h0;
   localparam logic [INT_W-1:0] INTMASK_RESET = 4'h0;

   typedef enum logic [2:0] {
      RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
   } urs_rx_e;

   typedef struct packed {
      logic parityErr;
      logic framingErr;
      logic [8:0] data;
   } urs_char_s;
endpackage
`default_nettype wire

// file: tb/urs_tx_model.sv
`default_nettype none
module urs_tx_model (
   input wire logic clk,
   output logic line
);
   timeunit 1ns;
   timeprecision 1ns;
   initial line = 1'b1;
   // Bit time fixed at 8 clocks; the bench programs the same divisor
   task automatic bitOut(input logic v);
      line <= v;
      repeat (8) @(posedge clk);
   endtask
   // Parity 1 even, 2 odd; a trailing idle bit lets the store land
   task automatic send(input logic [8:0] d, input int n, input int par, input logic stp);
      bitOut(1'b0);
      for (int i = 0; i < n; i++) bitOut(d[i]);
      if (par != 0) bitOut(^d[7:0] ^ (par == 2));
      bitOut(stp);
      bitOut(1'b1);
   endtask
endmodule
`default_nettype wire

// file: tb/urs_receive_status_assertions.sv
`default_nettype none
module urs_rs_checker
   import urs_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   input wire logic rxPin,
   input wire logic irq
);
   logic rd;
   assign rd = hsel && htrans[1] && hready && !hwrite;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   resp_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
   ready_up_a: assert property (!reset |=> hreadyout) else $error("hreadyout low");
   rdata_hold_a: assert property (!rd |=> $stable(hrdata)) else $error("hrdata moved");
   unmapped_zero_a: assert property (rd && haddr[7:0] > 8'h14 |=> hrdata == 32'h0) else $error("unmapped");
   sta_upper_a: assert property (rd && haddr[7:0] == STA_OFF |=> hrdata[31:6] == 26'h0) else $error("sta upper");
   rxd_upper_a: assert property (rd && haddr[7:0] == RXDATA_OFF |=> hrdata[31:9] == 23'h0) else $error("rxd upper");
   busy_idle_a: assert property (!rxPin [*6] ##0 (rd && haddr[7:0] == STA_OFF) |=> !hrdata[STA_RECEIVER_IDLE_FLAG])
      else $error("idle while busy");
   reset_quiet_a: assert property (disable iff (1'b0) reset |=> !irq && hrdata == 32'h0) else $error("reset");
endmodule
bind urs_receive_status urs_rs_checker chk_u (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
   .hresp(hresp), .rxPin(rxPin), .irq(irq));
`default_nettype wire

// file: tb/urs_receive_status_tb.sv
`default_nettype none
module urs_receive_status_tb
   import urs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
   logic hreadyout, hresp, rxPin, irq;
   int n_errors = 0, num_checks = 0;
   always #50 clk = ~clk;
   urs_receive_status dut_u (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .rxPin(rxPin), .irq(irq));
   urs_tx_model tx_u (.clk(clk), .line(rxPin));
   task automatic tally_and_finish();
      $display("Checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("Error at %0t: saw %h, want %h", $time, s, e);
      end
   endtask
   task automatic waitReady();
      int i;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (hreadyout !== 1'b1 && i < 50);
      if (i >= 50) begin
         n_errors++;
         tally_and_finish();
      end
   endtask
   // Entered just after a rising edge; returns just after the data phase edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      waitReady();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitReady();
      rdv = hrdata;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      check(rdv, e);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      rc(STA_OFF, 32'h10);
      rc(MODE_OFF, 32'h0);
      rc(BRG_OFF, {16'h0, BRG_RESET});
      rc(INTMASK_OFF, 32'h0);
      rc(8'h18, 32'h0);
      xfer(1'b1, BRG_OFF, 32'h8);
      xfer(1'b1, INTMASK_OFF, 32'h1);
      xfer(1'b1, STA_OFF, 32'h1F);
      rc(STA_OFF, 32'h10);
      for (int m = 0; m < 4; m++) begin
         xfer(1'b1, MODE_OFF, 32'(m) << MODE_PARITY_DATA_SELECT_LO);
         tx_u.send(9'h1A5, m == 3 ? 9 : 8, m == 3 ? 0 : m, 1'b1);
         rc(STA_OFF, 32'h11);
         check({31'h0, irq}, 32'h1);
         rc(RXDATA_OFF, m == 3 ? 32'h1A5 : 32'hA5);
         xfer(1'b1, INTSTAT_OFF, 32'h1);
         rc(STA_OFF, 32'h10);
         check({31'h0, irq}, 32'h0);
      end
      // Clean, bad parity, bad stop: flags must follow the head only
      xfer(1'b1, MODE_OFF, 32'h2);
      tx_u.send(9'h033, 8, 1, 1'b1);
      tx_u.send(9'h033, 8, 2, 1'b1);
      tx_u.send(9'h033, 8, 1, 1'b0);
      rc(STA_OFF, 32'h11);
      xfer(1'b1, INTMASK_OFF, 32'h0);
      rc(RXDATA_OFF, 32'h33);
      check({31'h0, irq}, 32'h0);
      rc(STA_OFF, 32'h19);
      rc(RXDATA_OFF, 32'h33);
      rc(STA_OFF, 32'h15);
      rc(RXDATA_OFF, 32'h33);
      rc(STA_OFF, 32'h10);
      xfer(1'b1, MODE_OFF, 32'h0);
      fork
         tx_u.send(9'h03C, 8, 0, 1'b1);
         begin
            repeat (12) @(posedge clk);
            rc(STA_OFF, 32'h0);
         end
      join
      repeat (3) tx_u.send(9'h03C, 8, 0, 1'b1);
      rc(STA_OFF, 32'h11);
      tx_u.send(9'h0C3, 8, 0, 1'b1);
      rc(STA_OFF, 32'h13);
      // All-ones data keeps the line high, so no false start after the abort
      fork
         tx_u.send(9'h0FF, 8, 0, 1'b1);
         begin
            repeat (30) @(posedge clk);
            xfer(1'b1, STA_OFF, 32'h0);
         end
      join
      rc(STA_OFF, 32'h10);
      xfer(1'b1, MODE_OFF, 32'h6);
      xfer(1'b1, STA_OFF, 32'h20);
      tx_u.send(9'h055, 9, 0, 1'b1);
      rc(STA_OFF, 32'h30);
      tx_u.send(9'h1AA, 9, 0, 1'b1);
      rc(RXDATA_OFF, 32'h1AA);
      xfer(1'b1, MODE_OFF, 32'h0);
      tx_u.send(9'h055, 8, 0, 1'b1);
      rc(STA_OFF, 32'h31);
      tally_and_finish();
   end
endmodule
`default_nettype wire
